// ==== src/csr_rate_regs.v ====
// Sample rate selector register bank behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "csr_defs.vh"
module csr_rate_regs #(
    parameter ADDR_W = 16
)
(
    // Clock, reset, enable
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // Write address channel
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    // Write data channel
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // Write response channel
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // Read address channel
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    // Read data channel
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Rate selections to the core
    output reg [3:0] haptic_fs_select,
    output reg [3:0] mute_mixer_fs_select,
    output reg [3:0] in_path_fs_select,
    output reg [3:0] out_path_fs_select,
    output reg [3:0] audio_port_one_fs_select,
    output reg [3:0] audio_port_two_fs_select,
    output reg [3:0] audio_port_three_fs_select,
    output reg [3:0] bus_rx_ch1_fs_select,
    output reg [3:0] bus_rx_ch2_fs_select,
    output reg [3:0] bus_rx_ch3_fs_select,
    output reg [3:0] bus_rx_ch4_fs_select,
    output reg [3:0] bus_rx_ch5_fs_select,
    output reg [3:0] bus_rx_ch6_fs_select
);

    // Latched write request
    reg [ADDR_W-1:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;

    // Word index to register select; low address bits are ignored
    function [`CSR_SEL_W-1:0] decode;
        input [ADDR_W-1:0] addr;
        reg [`CSR_IDX_W-1:0] idx;
        begin
            idx = addr[`CSR_IDX_MSB:`CSR_IDX_LSB];
            case (idx)
                `CSR_IDX_HAPTIC: decode = `CSR_SEL_HAPTIC;
                `CSR_IDX_MUTE_MIX: decode = `CSR_SEL_MUTE_MIX;
                `CSR_IDX_IN_PATH: decode = `CSR_SEL_IN_PATH;
                `CSR_IDX_OUT_PATH: decode = `CSR_SEL_OUT_PATH;
                `CSR_IDX_PORT_ONE: decode = `CSR_SEL_PORT_ONE;
                `CSR_IDX_PORT_TWO: decode = `CSR_SEL_PORT_TWO;
                `CSR_IDX_PORT_THREE: decode = `CSR_SEL_PORT_THREE;
                `CSR_IDX_RX_CH12: decode = `CSR_SEL_RX_CH12;
                `CSR_IDX_RX_CH34: decode = `CSR_SEL_RX_CH34;
                `CSR_IDX_RX_CH56: decode = `CSR_SEL_RX_CH56;
                default: decode = `CSR_SEL_NONE;
            endcase
        end
    endfunction

    // Accepts listed codes; secondary-domain codes only where allowed
    function code_ok;
        input [3:0] code;
        input allow_alt;
        begin
            case (code)
                `CSR_FS_SYS_ONE, `CSR_FS_SYS_TWO, `CSR_FS_SYS_THREE: code_ok = 1'b1;
                `CSR_FS_ALT_ONE, `CSR_FS_ALT_TWO: code_ok = allow_alt;
                default: code_ok = 1'b0;
            endcase
        end
    endfunction

    // New field value, or the old one when the lane is off or the code is refused
    function [3:0] upd;
        input [3:0] old;
        input [3:0] code;
        input lane;
        input allow_alt;
        begin
            if (lane && code_ok(code, allow_alt))
                upd = code;
            else
                upd = old;
        end
    endfunction

    // Read data for a register select; unused bits read as zero
    function [31:0] rd_word;
        input [`CSR_SEL_W-1:0] sel;
        begin
            rd_word = 32'h0000_0000;
            case (sel)
                `CSR_SEL_HAPTIC: rd_word[`CSR_HI_MSB:`CSR_HI_LSB] = haptic_fs_select;
                `CSR_SEL_MUTE_MIX: rd_word[`CSR_HI_MSB:`CSR_HI_LSB] = mute_mixer_fs_select;
                `CSR_SEL_IN_PATH: rd_word[`CSR_HI_MSB:`CSR_HI_LSB] = in_path_fs_select;
                `CSR_SEL_OUT_PATH: rd_word[`CSR_HI_MSB:`CSR_HI_LSB] = out_path_fs_select;
                `CSR_SEL_PORT_ONE: rd_word[`CSR_LO_MSB:`CSR_LO_LSB] = audio_port_one_fs_select;
                `CSR_SEL_PORT_TWO: rd_word[`CSR_LO_MSB:`CSR_LO_LSB] = audio_port_two_fs_select;
                `CSR_SEL_PORT_THREE: rd_word[`CSR_LO_MSB:`CSR_LO_LSB] = audio_port_three_fs_select;
                `CSR_SEL_RX_CH12:
                begin
                    rd_word[`CSR_HI_MSB:`CSR_HI_LSB] = bus_rx_ch2_fs_select;
                    rd_word[`CSR_MID_MSB:`CSR_MID_LSB] = bus_rx_ch1_fs_select;
                end
                `CSR_SEL_RX_CH34:
                begin
                    rd_word[`CSR_HI_MSB:`CSR_HI_LSB] = bus_rx_ch4_fs_select;
                    rd_word[`CSR_MID_MSB:`CSR_MID_LSB] = bus_rx_ch3_fs_select;
                end
                `CSR_SEL_RX_CH56:
                begin
                    rd_word[`CSR_HI_MSB:`CSR_HI_LSB] = bus_rx_ch6_fs_select;
                    rd_word[`CSR_MID_MSB:`CSR_MID_LSB] = bus_rx_ch5_fs_select;
                end
                default: rd_word = 32'h0000_0000;
            endcase
        end
    endfunction

    wire [`CSR_SEL_W-1:0] wr_sel = decode(wr_addr);
    wire [`CSR_SEL_W-1:0] rd_sel = decode(s_axi_araddr);
    wire [3:0] code_hi = wr_data[`CSR_HI_MSB:`CSR_HI_LSB];
    wire [3:0] code_mid = wr_data[`CSR_MID_MSB:`CSR_MID_LSB];
    wire [3:0] code_lo = wr_data[`CSR_LO_MSB:`CSR_LO_LSB];
    // Bits 14:11 live in byte lane 1, bits 6:3 and 3:0 in lane 0
    wire lane_hi = wr_strb[`CSR_LANE_HI];
    wire lane_lo = wr_strb[`CSR_LANE_LO];
    // Both halves of the write held and no response pending
    wire do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

    // Write channels
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSR_RESP_OKAY;
            wr_addr <= {ADDR_W{1'b0}};
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end
        else if (ce)
        begin
            // Address and data are taken in either order
            if (s_axi_awvalid && s_axi_awready)
            begin
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // Refused codes still answer OKAY; only an unmapped word is an error
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == `CSR_SEL_NONE) ? `CSR_RESP_SLVERR : `CSR_RESP_OKAY;
            end
            // Channels reopen only after the response is taken
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Core processing groups; a refused code leaves the running rate alone
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            haptic_fs_select <= `CSR_FS_RESET;
            mute_mixer_fs_select <= `CSR_FS_RESET;
            in_path_fs_select <= `CSR_FS_RESET;
            out_path_fs_select <= `CSR_FS_RESET;
        end
        else if (ce && do_write)
        begin
            case (wr_sel)
                `CSR_SEL_HAPTIC:
                    haptic_fs_select <= upd(haptic_fs_select, code_hi, lane_hi, 1'b1);
                `CSR_SEL_MUTE_MIX:
                    mute_mixer_fs_select <= upd(mute_mixer_fs_select, code_hi, lane_hi, 1'b1);
                // Secondary-domain codes refused: converter paths stay on the main clock
                `CSR_SEL_IN_PATH:
                    in_path_fs_select <= upd(in_path_fs_select, code_hi, lane_hi, 1'b0);
                `CSR_SEL_OUT_PATH:
                    out_path_fs_select <= upd(out_path_fs_select, code_hi, lane_hi, 1'b0);
                // Interface registers and unmapped words touch nothing here
                default:
                    haptic_fs_select <= haptic_fs_select;
            endcase
        end
    end

    // External interface groups
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            audio_port_one_fs_select <= `CSR_FS_RESET;
            audio_port_two_fs_select <= `CSR_FS_RESET;
            audio_port_three_fs_select <= `CSR_FS_RESET;
            bus_rx_ch1_fs_select <= `CSR_FS_RESET;
            bus_rx_ch2_fs_select <= `CSR_FS_RESET;
            bus_rx_ch3_fs_select <= `CSR_FS_RESET;
            bus_rx_ch4_fs_select <= `CSR_FS_RESET;
            bus_rx_ch5_fs_select <= `CSR_FS_RESET;
            bus_rx_ch6_fs_select <= `CSR_FS_RESET;
        end
        else if (ce && do_write)
        begin
            case (wr_sel)
                `CSR_SEL_PORT_ONE:
                    audio_port_one_fs_select <= upd(audio_port_one_fs_select, code_lo, lane_lo, 1'b1);
                `CSR_SEL_PORT_TWO:
                    audio_port_two_fs_select <= upd(audio_port_two_fs_select, code_lo, lane_lo, 1'b1);
                `CSR_SEL_PORT_THREE:
                    audio_port_three_fs_select <= upd(audio_port_three_fs_select, code_lo, lane_lo, 1'b1);
                `CSR_SEL_RX_CH12:
                begin
                    bus_rx_ch1_fs_select <= upd(bus_rx_ch1_fs_select, code_mid, lane_lo, 1'b1);
                    bus_rx_ch2_fs_select <= upd(bus_rx_ch2_fs_select, code_hi, lane_hi, 1'b1);
                end
                `CSR_SEL_RX_CH34:
                begin
                    bus_rx_ch3_fs_select <= upd(bus_rx_ch3_fs_select, code_mid, lane_lo, 1'b1);
                    bus_rx_ch4_fs_select <= upd(bus_rx_ch4_fs_select, code_hi, lane_hi, 1'b1);
                end
                `CSR_SEL_RX_CH56:
                begin
                    bus_rx_ch5_fs_select <= upd(bus_rx_ch5_fs_select, code_mid, lane_lo, 1'b1);
                    bus_rx_ch6_fs_select <= upd(bus_rx_ch6_fs_select, code_hi, lane_hi, 1'b1);
                end
                default:
                    audio_port_one_fs_select <= audio_port_one_fs_select;
            endcase
        end
    end

    // Read channels
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CSR_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word(rd_sel);
                s_axi_rresp <= (rd_sel == `CSR_SEL_NONE) ? `CSR_RESP_SLVERR : `CSR_RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ==== shared/csr_defs.vh ====
// Constants for the core sample rate selector register bank
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

// Register indices; the byte address is four times the index
`define CSR_IDX_HAPTIC 14'h0090
`define CSR_IDX_MUTE_MIX 14'h02C3
`define CSR_IDX_IN_PATH 14'h0308
`define CSR_IDX_OUT_PATH 14'h0408
`define CSR_IDX_PORT_ONE 14'h0503
`define CSR_IDX_PORT_TWO 14'h0543
`define CSR_IDX_PORT_THREE 14'h0583
`define CSR_IDX_RX_CH12 14'h05E5
`define CSR_IDX_RX_CH34 14'h05E6
`define CSR_IDX_RX_CH56 14'h05E7

// Word index bits within a byte address
`define CSR_IDX_MSB 15
`define CSR_IDX_LSB 2
`define CSR_IDX_W 14

// Byte lanes that guard the fields
`define CSR_LANE_HI 1
`define CSR_LANE_LO 0

// Register select codes from the address decoder
`define CSR_SEL_W 4
`define CSR_SEL_HAPTIC 4'h0
`define CSR_SEL_MUTE_MIX 4'h1
`define CSR_SEL_IN_PATH 4'h2
`define CSR_SEL_OUT_PATH 4'h3
`define CSR_SEL_PORT_ONE 4'h4
`define CSR_SEL_PORT_TWO 4'h5
`define CSR_SEL_PORT_THREE 4'h6
`define CSR_SEL_RX_CH12 4'h7
`define CSR_SEL_RX_CH34 4'h8
`define CSR_SEL_RX_CH56 4'h9
`define CSR_SEL_NONE 4'hF

// Field positions
`define CSR_HI_MSB 14
`define CSR_HI_LSB 11
`define CSR_MID_MSB 6
`define CSR_MID_LSB 3
`define CSR_LO_MSB 3
`define CSR_LO_LSB 0

// Selector codes
`define CSR_FS_SYS_ONE 4'h0
`define CSR_FS_SYS_TWO 4'h1
`define CSR_FS_SYS_THREE 4'h2
`define CSR_FS_ALT_ONE 4'h8
`define CSR_FS_ALT_TWO 4'h9
`define CSR_FS_RESET 4'h0

// Bus responses
`define CSR_RESP_OKAY 2'h0
`define CSR_RESP_SLVERR 2'h2

`endif

// ==== bench/csr_rate_props.sv ====
// Property checker for the rate selector register bank
`timescale 1ns/1ps
module csr_rate_props (
    // Clock, reset and enable
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // Bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    // Selectors
    input wire [3:0] haptic_fs_select,
    input wire [3:0] mute_mixer_fs_select,
    input wire [3:0] in_path_fs_select,
    input wire [3:0] out_path_fs_select,
    input wire [3:0] audio_port_one_fs_select,
    input wire [3:0] bus_rx_ch1_fs_select,
    input wire [3:0] bus_rx_ch2_fs_select
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire [27:0] sels = {haptic_fs_select, mute_mixer_fs_select, in_path_fs_select, out_path_fs_select,
        audio_port_one_fs_select, bus_rx_ch1_fs_select, bus_rx_ch2_fs_select};
    wire [4:0] hs = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid};
    function automatic bit ok(input [3:0] c);
        return c inside {4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
    endfunction
    rst_clear_a: assert property (disable iff (1'h0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && sels == 28'h0)
        else $error("state not cleared by reset");
    in_sys_a: assert property (in_path_fs_select < 4'h3)
        else $error("input path left main domain codes");
    out_sys_a: assert property (out_path_fs_select < 4'h3)
        else $error("output path left main domain codes");
    hap_code_a: assert property (ok(haptic_fs_select))
        else $error("haptic selector holds reserved code");
    mute_code_a: assert property (ok(mute_mixer_fs_select))
        else $error("mute mixer selector holds reserved code");
    port_code_a: assert property (ok(audio_port_one_fs_select))
        else $error("audio port selector holds reserved code");
    rx_code_a: assert property (ok(bus_rx_ch1_fs_select) && ok(bus_rx_ch2_fs_select))
        else $error("receive channel selector holds reserved code");
    sel_write_a: assert property ($changed(sels) |-> $rose(s_axi_bvalid))
        else $error("selector moved without a write response");
    wr_lat_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce) ##1 ce
        |=> s_axi_bvalid)
        else $error("write response late");
    ce_hold_a: assert property (!ce |=> $stable(sels) && $stable(hs))
        else $error("state moved while clock enable was low");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
endmodule
bind csr_rate_regs csr_rate_props props (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .haptic_fs_select,
    .mute_mixer_fs_select, .in_path_fs_select, .out_path_fs_select, .audio_port_one_fs_select,
    .bus_rx_ch1_fs_select, .bus_rx_ch2_fs_select);

// ==== bench/csr_rate_regs_test.sv ====
// Self-checking bench for the rate selector register bank
`timescale 1ns/1ps
`include "csr_defs.vh"
`define CHK(a, e) cmp(a, e);
module csr_rate_regs_test;
    // Drive and observe
    logic aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, seed = 32'h50FBC58B;
    logic [3:0] s_axi_wstrb = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] haptic_fs_select, mute_mixer_fs_select, in_path_fs_select, out_path_fs_select;
    logic [3:0] audio_port_one_fs_select, audio_port_two_fs_select, audio_port_three_fs_select;
    logic [3:0] bus_rx_ch1_fs_select, bus_rx_ch2_fs_select, bus_rx_ch3_fs_select;
    logic [3:0] bus_rx_ch4_fs_select, bus_rx_ch5_fs_select, bus_rx_ch6_fs_select;
    // Expected register images, in index order
    logic [31:0] ex [10];
    logic [13:0] ix [10] = '{`CSR_IDX_HAPTIC, `CSR_IDX_MUTE_MIX, `CSR_IDX_IN_PATH, `CSR_IDX_OUT_PATH,
        `CSR_IDX_PORT_ONE, `CSR_IDX_PORT_TWO, `CSR_IDX_PORT_THREE, `CSR_IDX_RX_CH12, `CSR_IDX_RX_CH34, `CSR_IDX_RX_CH56};
    logic [33:0] rq [$];
    logic [1:0] bq [$];
    int num_errors = 0, checks_done = 0, cyc = 0;
    wire [51:0] outs = {haptic_fs_select, mute_mixer_fs_select, in_path_fs_select, out_path_fs_select,
        audio_port_one_fs_select, audio_port_two_fs_select, audio_port_three_fs_select, bus_rx_ch1_fs_select,
        bus_rx_ch2_fs_select, bus_rx_ch3_fs_select, bus_rx_ch4_fs_select, bus_rx_ch5_fs_select, bus_rx_ch6_fs_select};
    csr_rate_regs dut (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .haptic_fs_select, .mute_mixer_fs_select, .in_path_fs_select, .out_path_fs_select,
        .audio_port_one_fs_select, .audio_port_two_fs_select, .audio_port_three_fs_select, .bus_rx_ch1_fs_select,
        .bus_rx_ch2_fs_select, .bus_rx_ch3_fs_select, .bus_rx_ch4_fs_select, .bus_rx_ch5_fs_select,
        .bus_rx_ch6_fs_select);
    initial forever #20 aclk = ~aclk;
    function automatic [31:0] xs(input [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Refused codes and disabled lanes keep the old field
    function automatic [3:0] upd(input [3:0] o, c, input a, l);
        return (l && (c < 4'h3 || a && (c == 4'h8 || c == 4'h9))) ? c : o;
    endfunction
    function automatic [51:0] exo();
        return {ex[0][14:11], ex[1][14:11], ex[2][14:11], ex[3][14:11], ex[4][3:0], ex[5][3:0], ex[6][3:0],
            ex[7][6:3], ex[7][14:11], ex[8][6:3], ex[8][14:11], ex[9][6:3], ex[9][14:11]};
    endfunction
    task automatic cmp(input [63:0] g, input [63:0] w);
        checks_done++;
        if (g !== w)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, w);
        end
    endtask
    task automatic wr(input [15:0] a, input [31:0] dv, input [3:0] s, input [1:0] e);
        bit fa = 0;
        bit fw = 0;
        bq.push_back(e);
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_wstrb <= s;
        s_axi_awprot <= seed[2:0];
        while (!(fa && fw))
        begin
            @(posedge aclk);
            fa |= s_axi_awready && ce;
            fw |= s_axi_wready && ce;
            s_axi_awvalid <= !fa;
            s_axi_wvalid <= !fw;
        end
        do @(posedge aclk); while (!(s_axi_bvalid && ce));
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input [15:0] a, input [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        s_axi_arprot <= seed[5:3];
        do @(posedge aclk); while (!(s_axi_arready && ce));
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!(s_axi_rvalid && ce));
        s_axi_rready <= 1'h0;
    endtask
    task automatic wchk(input int r, input [31:0] dv, input [3:0] s);
        bit a = r != 2 && r != 3;
        if (r < 4 || r > 6) ex[r][14:11] = upd(ex[r][14:11], dv[14:11], a, s[1]);
        if (r > 3 && r < 7) ex[r][3:0] = upd(ex[r][3:0], dv[3:0], 1'h1, s[0]);
        if (r > 6) ex[r][6:3] = upd(ex[r][6:3], dv[6:3], 1'h1, s[0]);
        wr({ix[r], seed[1:0]}, dv, s, `CSR_RESP_OKAY);
        `CHK(outs, exo())
        rd({ix[r], seed[3:2]}, {`CSR_RESP_OKAY, ex[r]});
    endtask
    task automatic rst_chk;
        aresetn <= 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        for (int r = 0; r < 10; r++) ex[r] = 0;
        for (int r = 0; r < 10; r++) rd({ix[r], 2'h0}, 34'h0);
        `CHK(outs, exo())
        $display("test reset values done");
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Monitor pops the oldest note per answer; also bounds the run
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready && ce) `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
        if (s_axi_bvalid && s_axi_bready && ce) `CHK(s_axi_bresp, bq.pop_front())
        cyc++;
        // Enable drops one cycle in five so handshakes also meet frozen edges
        ce <= cyc % 5 != 4;
        if (cyc == 6000)
        begin
            num_errors++;
            stop_test;
        end
    end
    initial
    begin
        rst_chk;
        for (int c = 0; c < 16; c++)
        begin
            for (int r = 0; r < 10; r++)
            begin
                seed = xs(seed);
                d = seed;
                d[14:11] = c[3:0];
                if (r > 6) d[6:3] = ~c[3:0]; else d[3:0] = c[3:0];
                wchk(r, d, seed[6:4] != 3'h0 ? 4'hF : seed[11:8]);
            end
        end
        $display("test all codes done");
        wr(16'h0244, 32'hFFFFFFFF, 4'hF, `CSR_RESP_SLVERR);
        rd(16'h0244, {`CSR_RESP_SLVERR, 32'h0});
        `CHK(outs, exo())
        $display("test unmapped done");
        rst_chk;
        stop_test;
    end
endmodule
